//--- src/ievt_unit.sv
// Interrupt and event transfer unit: nodes, arbiter, channels, traps
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module ievt_unit #(
   parameter int unsigned N = ievt_pkg::NODES,
   parameter int unsigned NCH = ievt_pkg::CHANS
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [N-1:0] src_req_i,
   input wire logic [4*ievt_pkg::SHARED_SRCS-1:0] shared_src_i,
   input wire logic [8*(N-ievt_pkg::SHARED_BASE)-1:0] source_select_register_i,
   input wire logic cfg_we_i,
   input wire logic [ievt_pkg::IDX_W-1:0] cfg_node_i,
   input wire logic cfg_request_set_bit_i,
   input wire logic cfg_enable_i,
   input wire logic [ievt_pkg::PRIO_W-1:0] cfg_prio_i,
   input wire logic cfg_use_chan_i,
   input wire logic [2:0] cfg_chan_i,
   input wire logic chan_load_i,
   input wire logic [2:0] chan_sel_i,
   input wire logic [ievt_pkg::ADDR_W-1:0] chan_src_i,
   input wire logic [ievt_pkg::ADDR_W-1:0] chan_dst_i,
   input wire logic [ievt_pkg::CNT_W-1:0] chan_cnt_i,
   input wire logic [3:0] chan_ctrl_i,
   input wire logic [ievt_pkg::PRIO_W-1:0] cpu_level_i,
   input wire logic jump_cache_i,
   input wire logic service_done_i,
   input wire logic [ievt_pkg::TRAPS-1:0] hw_trap_i,
   input wire logic [ievt_pkg::TRAPS-1:0] trap_flag_clear_i,
   input wire logic [ievt_pkg::ESR_PINS-1:0] ext_system_request_pin_i,
   input wire logic [2*ievt_pkg::ESR_PINS-1:0] esr_map_i,
   input wire logic sw_trap_i,
   input wire logic [ievt_pkg::VEC_W-1:0] sw_trap_num_i,
   input wire logic [ievt_pkg::XCH-1:0] ext_pin_i,
   input wire logic [2*ievt_pkg::XCH-1:0] edge_sel_i,
   input wire logic [ievt_pkg::XCH*ievt_pkg::XCH-1:0] route_i,
   input wire logic [2*ievt_pkg::XCH-1:0] gate_mode_i,
   input wire logic [ievt_pkg::XCH-1:0] pattern_i,
   output logic [ievt_pkg::XCH-1:0] router_event_o,
   output logic [N-1:0] pending_o,
   output logic vec_req_o,
   output logic [ievt_pkg::VEC_W-1:0] vec_addr_o,
   output logic [ievt_pkg::PRIO_W-1:0] vec_level_o,
   output logic xfer_o,
   output logic xfer_word_o,
   output logic [ievt_pkg::ADDR_W-1:0] xfer_src_o,
   output logic [ievt_pkg::ADDR_W-1:0] xfer_dst_o,
   output logic trap_active_o,
   output logic [ievt_pkg::TRAPS-1:0] trap_flag_register_o
);
   initial begin
      if (N <= ievt_pkg::SHARED_BASE || N > 128 || NCH != 8) $error("Unsupported node or channel count");
   end
   localparam int unsigned NS = N - ievt_pkg::SHARED_BASE;
   // ---------------------------------------------------------------------
   // Node state
   // ---------------------------------------------------------------------
   logic [N-1:0] pend_q, pend_d, en_q, en_d, use_ch_q, use_ch_d, raw;
   logic [ievt_pkg::PRIO_W-1:0] prio_q [N], prio_d [N];
   logic [2:0] chn_q [N], chn_d [N];
   logic [ievt_pkg::XCH-1:0] rt_ev;
   typedef ievt_pkg::ievt_state_e ievt_state_e_t;
   ievt_state_e_t st_q, st_d;
   logic [3:0] wait_q, wait_d;
   logic [ievt_pkg::IDX_W-1:0] sel_q, sel_d;
   logic [ievt_pkg::IDX_W-1:0] win;
   logic [ievt_pkg::PRIO_W-1:0] win_p;
   logic win_ok;
   logic [NCH-1:0] serve;
   logic [ievt_pkg::ADDR_W-1:0] c_src [NCH], c_dst [NCH];
   logic [ievt_pkg::CNT_W-1:0] c_cnt [NCH];
   logic [ievt_pkg::TRAPS-1:0] tfr_q, tfr_d, trap_ev;
   logic [ievt_pkg::ESR_PINS-1:0] esr_q;
   logic srq_ev0, srq_ev1;
   logic vreq_q, vreq_d, xfer_q, xfer_d, word_q, word_d, tact_q, tact_d;
   logic [ievt_pkg::VEC_W-1:0] vaddr_q, vaddr_d;
   logic [ievt_pkg::PRIO_W-1:0] vlvl_q, vlvl_d;
   logic [ievt_pkg::ADDR_W-1:0] xs_q, xs_d, xd_q, xd_d;
   logic [ievt_pkg::VEC_W-1:0] tvec_q, tvec_d;
   logic trap_pend;

   function automatic logic [ievt_pkg::VEC_W-1:0] node_vec(input logic [ievt_pkg::IDX_W-1:0] n);
      node_vec = ievt_pkg::NODE_VEC_BASE + ievt_pkg::VEC_W'(n);
   endfunction : node_vec

   ievt_edge_router #(.CH(ievt_pkg::XCH)) u_router (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(ext_pin_i),
      .edge_sel_i(edge_sel_i),
      .route_i(route_i),
      .gate_mode_i(gate_mode_i),
      .pattern_i(pattern_i),
      .event_o(rt_ev)
   );

   // ---------------------------------------------------------------------
   // Source selection for shared nodes
   // ---------------------------------------------------------------------
   always_comb begin
      raw = src_req_i;
      raw[ievt_pkg::XCH-1:0] = src_req_i[ievt_pkg::XCH-1:0] | rt_ev;
      for (int s = 0; s < NS; s++) begin
         // Low four select bits pick one of the shared sources
         raw[ievt_pkg::SHARED_BASE+s] = shared_src_i[source_select_register_i[8*s +: 4]];
      end
   end

   // ---------------------------------------------------------------------
   // Arbiter: highest enabled priority above CPU level
   // ---------------------------------------------------------------------
   always_comb begin
      win = '0;
      win_p = '0;
      win_ok = 1'b0;
      for (int n = 0; n < N; n++) begin
         if (pend_q[n] && en_q[n] && prio_q[n] > cpu_level_i && (!win_ok || prio_q[n] > win_p)) begin
            win = ievt_pkg::IDX_W'(n);
            win_p = prio_q[n];
            win_ok = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Traps and system request pins
   // ---------------------------------------------------------------------
   always_comb begin
      srq_ev0 = 1'b0;
      srq_ev1 = 1'b0;
      for (int e = 0; e < ievt_pkg::ESR_PINS; e++) begin
         if (ext_system_request_pin_i[e] && !esr_q[e]) begin
            srq_ev0 = srq_ev0 | esr_map_i[2*e];
            srq_ev1 = srq_ev1 | esr_map_i[2*e+1];
         end
      end
      trap_ev = hw_trap_i;
      tfr_d = (tfr_q & ~trap_flag_clear_i) | trap_ev;
      trap_pend = |trap_ev || srq_ev0 || srq_ev1;
   end

   // ---------------------------------------------------------------------
   // Service sequencer
   // ---------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      wait_d = wait_q;
      sel_d = sel_q;
      pend_d = pend_q | raw;
      en_d = en_q;
      use_ch_d = use_ch_q;
      prio_d = prio_q;
      chn_d = chn_q;
      serve = '0;
      vreq_d = 1'b0;
      xfer_d = 1'b0;
      word_d = word_q;
      vaddr_d = vaddr_q;
      vlvl_d = vlvl_q;
      xs_d = xs_q;
      xd_d = xd_q;
      tact_d = tact_q;
      tvec_d = tvec_q;
      if (cfg_we_i) begin
         pend_d[cfg_node_i] = raw[cfg_node_i] | cfg_request_set_bit_i;
         en_d[cfg_node_i] = cfg_enable_i;
         prio_d[cfg_node_i] = cfg_prio_i;
         use_ch_d[cfg_node_i] = cfg_use_chan_i;
         chn_d[cfg_node_i] = cfg_chan_i;
      end
      if (tact_q && service_done_i) tact_d = 1'b0;
      // Trap beats everything; a running trap blocks interrupts
      if (trap_pend && !tact_q) begin
         tact_d = 1'b1;
         vreq_d = 1'b1;
         st_d = ievt_pkg::ST_IDLE;
         for (int t = ievt_pkg::TRAPS - 1; t >= 0; t--) begin
            if (trap_ev[t]) vaddr_d = ievt_pkg::TRAP_VEC_BASE + ievt_pkg::VEC_W'(t);
         end
         if (srq_ev1) vaddr_d = ievt_pkg::SRQ1_VEC;
         if (srq_ev0) vaddr_d = ievt_pkg::SRQ0_VEC;
         vlvl_d = '1;
      end else if (sw_trap_i && !tact_q) begin
         vreq_d = 1'b1;
         vaddr_d = sw_trap_num_i;
         vlvl_d = cpu_level_i;
      end else if (!tact_q) begin
         case (st_q)
            ievt_pkg::ST_IDLE: begin
               if (win_ok) begin
                  sel_d = win;
                  pend_d[win] = raw[win];
                  wait_d = jump_cache_i ? ievt_pkg::LAT_JC_CYC : ievt_pkg::LAT_NOJC_CYC;
                  st_d = ievt_pkg::ST_WAIT;
               end
            end
            ievt_pkg::ST_WAIT: begin
               wait_d = wait_q - 4'h1;
               if (wait_q == 4'h2) begin
                  st_d = (use_ch_q[sel_q] && c_cnt[chn_q[sel_q]] != ievt_pkg::CNT_ZERO)
                         ? ievt_pkg::ST_XFER : ievt_pkg::ST_VEC;
               end
            end
            ievt_pkg::ST_XFER: begin
               serve[chn_q[sel_q]] = 1'b1;
               xfer_d = 1'b1;
               word_d = chan_ctrl_i[ievt_pkg::CC_WORD];
               xs_d = c_src[chn_q[sel_q]];
               xd_d = c_dst[chn_q[sel_q]];
               st_d = ievt_pkg::ST_IDLE;
            end
            ievt_pkg::ST_VEC: begin
               vreq_d = 1'b1;
               vaddr_d = node_vec(sel_q);
               vlvl_d = prio_q[sel_q];
               st_d = ievt_pkg::ST_IDLE;
            end
            default: st_d = ievt_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Transfer channels
   // ---------------------------------------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      ievt_chan u_chan (
         .clk_sys_i(clk_sys_i),
         .reset_i(reset_i),
         .load_i(chan_load_i && chan_sel_i == 3'(c)),
         .src_i(chan_src_i),
         .dst_i(chan_dst_i),
         .cnt_i(chan_cnt_i),
         .ctrl_i(chan_ctrl_i),
         .serve_i(serve[c]),
         .src_o(c_src[c]),
         .dst_o(c_dst[c]),
         .cnt_o(c_cnt[c])
      );
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= ievt_pkg::ST_IDLE;
         wait_q <= '0;
         sel_q <= '0;
         pend_q <= '0;
         en_q <= '0;
         use_ch_q <= '0;
         prio_q <= '{default: '0};
         chn_q <= '{default: '0};
         tfr_q <= '0;
         esr_q <= '0;
         vreq_q <= 1'b0;
         xfer_q <= 1'b0;
         word_q <= 1'b0;
         vaddr_q <= '0;
         vlvl_q <= '0;
         xs_q <= '0;
         xd_q <= '0;
         tact_q <= 1'b0;
         tvec_q <= '0;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
         sel_q <= sel_d;
         pend_q <= pend_d;
         en_q <= en_d;
         use_ch_q <= use_ch_d;
         prio_q <= prio_d;
         chn_q <= chn_d;
         tfr_q <= tfr_d;
         esr_q <= ext_system_request_pin_i;
         vreq_q <= vreq_d;
         xfer_q <= xfer_d;
         word_q <= word_d;
         vaddr_q <= vaddr_d;
         vlvl_q <= vlvl_d;
         xs_q <= xs_d;
         xd_q <= xd_d;
         tact_q <= tact_d;
         tvec_q <= tvec_d;
      end
   end

   assign router_event_o = rt_ev;
   assign pending_o = pend_q;
   assign vec_req_o = vreq_q;
   assign vec_addr_o = vaddr_q;
   assign vec_level_o = vlvl_q;
   assign xfer_o = xfer_q;
   assign xfer_word_o = word_q;
   assign xfer_src_o = xs_q;
   assign xfer_dst_o = xd_q;
   assign trap_active_o = tact_q;
   assign trap_flag_register_o = tfr_q;

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   a_xfer_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      xfer_o |=> !xfer_o) else $error("Transfer longer than one cycle");
   a_trap_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      hw_trap_i[0] |=> trap_flag_register_o[0]) else $error("Trap flag not set");
   a_trap_block: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      trap_active_o && !service_done_i |=> !xfer_o) else $error("Transfer during trap");
   a_trap_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      hw_trap_i != '0 && !trap_active_o |=> vec_req_o && trap_active_o)
      else $error("Trap not taken");
   a_grant_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      st_q == ievt_pkg::ST_IDLE && win_ok && !tact_q && !trap_pend && !sw_trap_i && !cfg_we_i
      && !raw[win] |=> !pending_o[$past(win)]) else $error("Pending flag not cleared");
   a_sw_trap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      sw_trap_i && !tact_q && !trap_pend |=> vec_req_o && vec_addr_o == $past(sw_trap_num_i))
      else $error("Software trap not started");
   a_sw_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      cfg_we_i && cfg_request_set_bit_i |=> pending_o[$past(cfg_node_i)] || vec_req_o || xfer_o
      || st_q == ievt_pkg::ST_WAIT) else $error("Software request lost");
   a_latency: assert property (@(posedge clk_sys_i) disable iff (reset_i || tact_q)
      st_q == ievt_pkg::ST_IDLE && st_d == ievt_pkg::ST_WAIT && jump_cache_i && !trap_pend
      |-> ##[6:6] (st_q == ievt_pkg::ST_XFER || st_q == ievt_pkg::ST_VEC || tact_q))
      else $error("Service start latency wrong");
   c_xfer: cover property (@(posedge clk_sys_i) xfer_o);
   c_vec: cover property (@(posedge clk_sys_i) vec_req_o && !trap_active_o);
   c_trap: cover property (@(posedge clk_sys_i) trap_active_o && vec_req_o);
endmodule : ievt_unit
`default_nettype wire

//--- common/ievt_pkg.sv
// Package: constants and types of the interrupt and event transfer unit
package ievt_pkg;
   localparam int unsigned NODES = 112;
   localparam int unsigned PRIO_W = 4;
   localparam int unsigned CHANS = 8;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned VEC_W = 8;
   localparam int unsigned IDX_W = 7;
   localparam int unsigned XCH = 4;
   localparam int unsigned SHARED_BASE = 104;
   localparam int unsigned SHARED_SRCS = 4;
   localparam int unsigned TRAPS = 8;
   localparam int unsigned ESR_PINS = 3;
   // Latency figures in CPU clocks, as published
   localparam int unsigned LAT_JC_CLK = 7;
   localparam int unsigned LAT_NOJC_CLK = 11;
   localparam logic [3:0] LAT_JC_CYC = 4'(LAT_JC_CLK - 1);
   localparam logic [3:0] LAT_NOJC_CYC = 4'(LAT_NOJC_CLK - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   // Channel control layout
   localparam int unsigned CC_WORD = 0;
   localparam int unsigned CC_INC_SRC = 1;
   localparam int unsigned CC_INC_DST = 2;
   localparam int unsigned CC_CONT = 3;
   localparam logic [VEC_W-1:0] TRAP_VEC_BASE = 8'h00;
   localparam logic [VEC_W-1:0] SRQ0_VEC = 8'h08;
   localparam logic [VEC_W-1:0] SRQ1_VEC = 8'h09;
   localparam logic [VEC_W-1:0] NODE_VEC_BASE = 8'h10;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] GATE_PASS = 2'h0;
   localparam logic [1:0] GATE_MATCH = 2'h1;
   localparam logic [1:0] GATE_MISS = 2'h2;
   typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_XFER, ST_VEC, ST_TRAP} ievt_state_e;
endpackage : ievt_pkg

//--- src/ievt_edge_router.sv
// External request router: edge detection, routing matrix, gating units
`timescale 1ns/10ps
`default_nettype none
module ievt_edge_router #(
   parameter int unsigned CH = ievt_pkg::XCH
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [CH-1:0] pin_i,
   input wire logic [2*CH-1:0] edge_sel_i,
   input wire logic [CH*CH-1:0] route_i,
   input wire logic [2*CH-1:0] gate_mode_i,
   input wire logic [CH-1:0] pattern_i,
   output logic [CH-1:0] event_o
);
   initial begin
      if (CH < 1 || CH > 8) $error("Router channel count out of range");
   end
   logic [CH-1:0] prev_q, prev_d, ev_q, ev_d, det;
   logic [CH-1:0] level_q, level_d;
   always_comb begin
      prev_d = pin_i;
      level_d = level_q;
      ev_d = '0;
      for (int i = 0; i < CH; i++) begin
         det[i] = (edge_sel_i[2*i +: 2] & ievt_pkg::EDGE_RISE) != 2'h0 && pin_i[i] && !prev_q[i] ||
                  (edge_sel_i[2*i +: 2] & ievt_pkg::EDGE_FALL) != 2'h0 && !pin_i[i] && prev_q[i];
         if (det[i]) begin
            level_d[i] = pin_i[i];
         end
      end
      for (int o = 0; o < CH; o++) begin
         // Gating compares the pin levels latched at each input's last detected edge against the pattern
         logic any;
         logic hit;
         any = |(det & route_i[CH*o +: CH]);
         hit = ((level_d ^ pattern_i) & route_i[CH*o +: CH]) == '0;
         case (gate_mode_i[2*o +: 2])
            ievt_pkg::GATE_PASS: ev_d[o] = any;
            ievt_pkg::GATE_MATCH: ev_d[o] = any && hit;
            ievt_pkg::GATE_MISS: ev_d[o] = any && !hit;
            default: ev_d[o] = 1'b0;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         prev_q <= '0;
         level_q <= '0;
         ev_q <= '0;
      end else begin
         prev_q <= prev_d;
         level_q <= level_d;
         ev_q <= ev_d;
      end
   end
   assign event_o = ev_q;
   a_rise_event: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (edge_sel_i == {CH{ievt_pkg::EDGE_RISE}} && gate_mode_i == '0 && route_i[0 +: CH] == 1
       && pin_i[0] && !prev_q[0]) |=> event_o[0]) else $error("Rising edge not routed");
   a_no_event: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (route_i == '0) |=> event_o == '0) else $error("Event without route");
endmodule : ievt_edge_router
`default_nettype wire

//--- src/ievt_chan.sv
// Single cycle transfer channel: pointers and transfer counter
`timescale 1ns/10ps
`default_nettype none
module ievt_chan #(
   parameter int unsigned AW = ievt_pkg::ADDR_W,
   parameter int unsigned CW = ievt_pkg::CNT_W
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [AW-1:0] src_i,
   input wire logic [AW-1:0] dst_i,
   input wire logic [CW-1:0] cnt_i,
   input wire logic [3:0] ctrl_i,
   input wire logic serve_i,
   output logic [AW-1:0] src_o,
   output logic [AW-1:0] dst_o,
   output logic [CW-1:0] cnt_o
);
   initial begin
      if (CW < 2 || AW < 2) $error("Channel widths too small");
   end
   logic [AW-1:0] src_q, src_d, dst_q, dst_d, step;
   logic [CW-1:0] cnt_q, cnt_d;
   always_comb begin
      step = ctrl_i[ievt_pkg::CC_WORD] ? AW'(2) : AW'(1);
      src_d = src_q;
      dst_d = dst_q;
      cnt_d = cnt_q;
      if (load_i) begin
         src_d = src_i;
         dst_d = dst_i;
         cnt_d = cnt_i;
      end else if (serve_i) begin
         if (ctrl_i[ievt_pkg::CC_INC_SRC]) src_d = src_q + step;
         if (ctrl_i[ievt_pkg::CC_INC_DST]) dst_d = dst_q + step;
         if (!ctrl_i[ievt_pkg::CC_CONT]) cnt_d = cnt_q - ievt_pkg::CNT_ONE;
      end
   end
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         src_q <= '0;
         dst_q <= '0;
         cnt_q <= '0;
      end else begin
         src_q <= src_d;
         dst_q <= dst_d;
         cnt_q <= cnt_d;
      end
   end
   assign src_o = src_q;
   assign dst_o = dst_q;
   assign cnt_o = cnt_q;
   a_cnt_dec: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (serve_i && !load_i && !ctrl_i[ievt_pkg::CC_CONT]) |=> cnt_o == CW'($past(cnt_o) - 1'b1))
      else $error("Counter not decremented");
   a_cnt_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (serve_i && !load_i && ctrl_i[ievt_pkg::CC_CONT]) |=> $stable(cnt_o))
      else $error("Continuous mode changed counter");
endmodule : ievt_chan
`default_nettype wire

//--- tb/ievt_cpu_model.sv
// CPU core model that ends the first trap service after four cycles and each later one after a random delay
`timescale 1ns/10ps
`default_nettype none
module ievt_cpu_model (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic trap_active_i,
   output logic service_done_o
);
   // -----------------------------------------
   // Service length
   // -----------------------------------------
   // At least four cycles, so pending checks land while a trap runs
   int unsigned cnt_q;
   int unsigned lim_q;
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= 0;
         lim_q <= 4;
         service_done_o <= 1'b0;
      end else begin
         service_done_o <= 1'b0;
         if (trap_active_i && !service_done_o) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q + 1 >= lim_q) begin
               service_done_o <= 1'b1;
               cnt_q <= 0;
               lim_q <= $urandom_range(4, 9);
            end
         end
      end
   end
endmodule : ievt_cpu_model
`default_nettype wire

//--- tb/test_interrupt_and_event_transfer_unit.sv
// Testbench: drives the transfer unit and scores every service
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_and_event_transfer_unit;
   logic clk_sys_i = 0;
   logic reset_i = 1;
   logic [111:0] req = '0;
   logic [111:0] pend;
   logic we = 0, sb = 0, uc = 0, ld = 0, jc = 1, sw = 0, done, vr, xf, ta;
   logic [6:0] node = '0;
   logic [3:0] pr = '0, lvl = '0, ctl = '0, xp = '0;
   logic [2:0] ch = '0, cs = '0, ext_system_request_pin = '0;
   logic [23:0] sa = '0, da = '0, xs;
   logic [7:0] cn = '0, ht = '0, tn = '0, va, tf, es = 8'h01;
   logic [5:0] em = 6'b001001;
   logic [15:0] rt = 16'h0001, ss = '0;
   logic [63:0] sel = '0;
   logic [7:0] tc = '0, gm = '0;
   logic [3:0] pat = '0;
   logic en = 1;
   logic [24:0] exp_q[$];
   int n_errors = 0;
   int num_checks = 0;
   int r;
   // -----------------------------------------
   // Design, CPU model, clock
   // -----------------------------------------
   ievt_unit uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .src_req_i(req), .shared_src_i(ss),
      .source_select_register_i(sel), .cfg_we_i(we), .cfg_node_i(node),
      .cfg_request_set_bit_i(sb), .cfg_enable_i(en), .cfg_prio_i(pr), .cfg_use_chan_i(uc),
      .cfg_chan_i(ch), .chan_load_i(ld), .chan_sel_i(cs), .chan_src_i(sa), .chan_dst_i(da),
      .chan_cnt_i(cn), .chan_ctrl_i(ctl), .cpu_level_i(lvl), .jump_cache_i(jc),
      .service_done_i(done), .hw_trap_i(ht), .trap_flag_clear_i(tc),
      .ext_system_request_pin_i(ext_system_request_pin), .esr_map_i(em), .sw_trap_i(sw), .sw_trap_num_i(tn),
      .ext_pin_i(xp), .edge_sel_i(es), .route_i(rt), .gate_mode_i(gm), .pattern_i(pat),
      .router_event_o(), .pending_o(pend), .vec_req_o(vr), .vec_addr_o(va), .vec_level_o(),
      .xfer_o(xf), .xfer_word_o(), .xfer_src_o(xs), .xfer_dst_o(), .trap_active_o(ta),
      .trap_flag_register_o(tf));
   ievt_cpu_model cpu (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .trap_active_i(ta),
      .service_done_o(done));
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // -----------------------------------------
   // Checking and stimulus tasks
   // -----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic results;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   // Waits for all noted services and for the trap service to end
   task automatic drain;
      for (int i = 0; i < 80; i++) begin
         if (exp_q.size() == 0 && ta === 1'b0) return;
         @(posedge clk_sys_i);
      end
      check(exp_q.size(), 0);
      results;
   endtask : drain
   task automatic cfg(input logic [6:0] n, input logic [3:0] p, input logic u,
      input logic [2:0] c, input logic s);
      @(posedge clk_sys_i);
      {we, node, pr, uc, ch, sb} <= {1'b1, n, p, u, c, s};
      @(posedge clk_sys_i);
      we <= 0;
   endtask : cfg
   task automatic chan(input logic [2:0] c, input logic [23:0] s, input logic [7:0] n,
      input logic [3:0] m);
      @(posedge clk_sys_i);
      {ld, cs, sa, da, cn, ctl} <= {1'b1, c, s, s + 24'h1000, n, m};
      @(posedge clk_sys_i);
      ld <= 0;
   endtask : chan
   task automatic fire(input logic [7:0] h, input logic [2:0] e, input logic s,
      input logic [7:0] n, input logic [24:0] v);
      exp_q.push_back(v);
      @(posedge clk_sys_i);
      {ht, ext_system_request_pin, sw, tn} <= {h, e, s, n};
      @(posedge clk_sys_i);
      {ht, sw} <= '0;
   endtask : fire
   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      req[i] <= 1;
      @(posedge clk_sys_i);
      req[i] <= 0;
   endtask : pulse
   // Scores each vector or transfer against the oldest note
   always @(posedge clk_sys_i) begin
      if (!reset_i && (vr === 1'b1 || xf === 1'b1)) begin
         if (exp_q.size() == 0) check(1, 0);
         else check(xf ? {8'h1, xs} : {24'h0, va}, {7'h0, exp_q.pop_front()});
      end
   end
   initial begin
      void'($urandom(92144));
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 0;
      @(negedge clk_sys_i);
      check(|pend, 0);
      exp_q.push_back(25'h15);
      cfg(5, 3, 0, 0, 1);
      drain;
      check(pend[5], 0);
      r = $urandom_range(1, 13);
      @(posedge clk_sys_i);
      lvl <= 4'hf;
      cfg(20, 4'(r), 0, 0, 1);
      cfg(21, 4'(r + 1), 0, 0, 1);
      cfg(22, 4'(r), 0, 0, 1);
      repeat (12) @(posedge clk_sys_i);
      check(pend[22:20], 3'h7);
      exp_q.push_back(25'h25);
      lvl <= 4'(r);
      drain;
      check(pend[22:20], 3'h5);
      exp_q.push_back(25'h24);
      exp_q.push_back(25'h26);
      lvl <= 0;
      drain;
      jc <= 0;
      exp_q.push_back(25'h2e);
      cfg(30, 2, 0, 0, 0);
      pulse(30);
      drain;
      // Byte moves, both pointers step, count two then vector
      chan(2, 24'h1000, 8'h2, 4'h6);
      cfg(40, 5, 1, 2, 0);
      for (int k = 0; k < 3; k++) begin
         exp_q.push_back(k < 2 ? {1'b1, 24'h1000 + 24'(k)} : 25'h38);
         pulse(40);
         drain;
      end
      chan(3, 24'h3000, 8'h1, 4'h8);
      cfg(41, 5, 1, 3, 0);
      for (int k = 0; k < 2; k++) begin
         exp_q.push_back({1'b1, 24'h3000});
         pulse(41);
         drain;
      end
      fire(8'h08, 0, 0, 0, 25'h03);
      cfg(50, 6, 0, 0, 1);
      @(negedge clk_sys_i);
      check(pend[50], 1);
      check(tf[3], 1);
      exp_q.push_back(25'h42);
      drain;
      fire(0, 3'h2, 0, 0, 25'h09);
      drain;
      fire(0, 3'h3, 0, 0, 25'h08);
      drain;
      fire(0, 3'h3, 1, 8'h20, 25'h20);
      drain;
      @(posedge clk_sys_i);
      tc <= 8'h08;
      gm <= 8'h01;
      pat <= 4'h1;
      @(posedge clk_sys_i);
      tc <= 8'h00;
      @(negedge clk_sys_i);
      check(tf[3], 0);
      @(posedge clk_sys_i);
      xp <= 4'h1;
      repeat (4) @(posedge clk_sys_i);
      check(pend[0], 1);
      // Shared node 104 listens to shared source 5
      sel <= 64'h5;
      @(posedge clk_sys_i);
      ss <= 16'h0020;
      @(posedge clk_sys_i);
      ss <= 16'h0000;
      repeat (2) @(posedge clk_sys_i);
      check(pend[104], 1);
      // A disabled node keeps its request and is never served
      en <= 0;
      cfg(60, 7, 0, 0, 1);
      repeat (14) @(posedge clk_sys_i);
      check(pend[60], 1);
      check(exp_q.size(), 0);
      en <= 1;
      results;
   end
endmodule : test_interrupt_and_event_transfer_unit
`default_nettype wire
